// file: hdl/drop_motion_detect.sv
// free-fall and wake-up event detector with two event pins
`timescale 1ns/1ps
`include "motion_cfg.svh"
// Notes on behaviour
// (R1) free fall when all three axes sit inside the zero-g zone
// (R2) free fall only after the zone holds the programmed duration
// (R3) needs global enable; per-pin drop routing; drop flag always in source
// (R4) without latch, free-fall output drops once zone is left
// (R5) latched routed drop holds the pin until source read clears it
// (R6) latch has no effect on an event routed to neither pin
// (R7) drop threshold code maps to 156..500 mg regardless of scale
// (R8) drop duration is a six-bit count of sample periods
// (R9) wake uses slope filter when select is 0, high-pass when 1
// (R10) wake when absolute filtered value exceeds threshold for enough samples
// (R11) wake threshold six bits, step is full scale over 64
// (R12) wake duration two bits, one sample period per step
// (R13) zero wake duration raises wake on every exceeding sample
// (R14) wake needs enable and routing; source shows wake and axis flags
// (R15) without latch, wake output drops once data falls below threshold
// (R16) latched routed wake holds the pin until source read clears it
// (R17) slope is half of current minus previous, previous zero at start
// (R18) single exceeding sample gives a one sample period wake pulse
// (R19) host ignores or avoids the first-sample spurious wake
// (R20) several events on one pin combine by OR
// (R21) polarity 0 gives active high pins, 1 gives active low
// (R22) detectors step once per sample, counters reset when condition fails
// (R23) source read returns current flags and clears latched indications
module drop_motion_detect
  import motion_pkg::*;
#(
  parameter int W = `SAMPLE_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sample_stb,
  input wire logic [W-1:0] accel_x,
  input wire logic [W-1:0] accel_y,
  input wire logic [W-1:0] accel_z,
  input wire logic [`FULL_SCALE_W-1:0] accel_full_scale,
  input wire logic events_enable,
  input wire logic latch_request,
  input wire logic wake_filter_select,
  input wire logic pin_polarity_select,
  input wire logic pin1_drop_route,
  input wire logic pin2_drop_route,
  input wire logic pin1_wake_route,
  input wire logic pin2_wake_route,
  input wire logic [`DROP_THS_W-1:0] drop_threshold_code,
  input wire logic [`DROP_DUR_W-1:0] drop_duration_count,
  input wire logic [`WAKE_THS_W-1:0] wake_threshold_field,
  input wire logic [`WAKE_DURATION_FIELD_W-1:0] wake_duration_field,
  input wire logic source_read,
  output logic [5:0] motion_source_reg,
  output logic event_pin_one,
  output logic event_pin_two
);
  // carrier between this detector and its filter
  axis_if #(.W(W)) ax ();
  // duration counters and live event flags
  logic [`DROP_DUR_W-1:0] drop_cnt_q;
  logic [`DROP_DUR_W-1:0] drop_cnt_d;
  logic [`WAKE_DURATION_FIELD_W:0] wake_cnt_q;
  logic [`WAKE_DURATION_FIELD_W:0] wake_cnt_d;
  logic drop_live_q;
  logic drop_live_d;
  logic wake_live_q;
  logic wake_live_d;
  axis_bits_t axis_q;
  axis_bits_t axis_d;
  // latched indications, source word and pin registers
  logic drop_latch_q;
  logic drop_latch_d;
  logic wake_latch_q;
  logic wake_latch_d;
  source_word_t src_q;
  source_word_t src_d;
  logic pin1_q;
  logic pin1_d;
  logic pin2_q;
  logic pin2_d;
  // thresholds in sample counts
  logic [W-1:0] drop_lsb;
  logic [W-1:0] wake_lsb;
  // per axis filtered magnitude and raw sample
  logic [W-1:0] mag [3];
  logic [W-1:0] raw [3];
  // comparison results and event signals
  axis_bits_t in_zone;
  axis_bits_t over;
  logic drop_cond;
  logic wake_cond;
  logic drop_hit;
  logic wake_hit;
  logic drop_routed;
  logic wake_routed;
  logic drop_sig;
  logic wake_sig;

  // refuse widths the threshold arithmetic cannot serve
  if (W < 12 || W > 24) begin : g_bad_width
    $error("sample width must be 12 to 24 bits");
  end

  ////////////////////////////////////////////////////////////////
  // filter instance
  assign ax.raw_x = accel_x;
  assign ax.raw_y = accel_y;
  assign ax.raw_z = accel_z;

  // filter history restarts whenever events are disabled
  wake_filter #(.W(W)) u_filter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sample_stb(sample_stb),
    .filter_enable(events_enable),
    .wake_filter_select(wake_filter_select),
    .ax(ax)
  );

  // filtered magnitudes for the wake test, raw samples for the zone test
  assign mag[0] = ax.mag_x;
  assign mag[1] = ax.mag_y;
  assign mag[2] = ax.mag_z;
  assign raw[0] = accel_x;
  assign raw[1] = accel_y;
  assign raw[2] = accel_z;

  ////////////////////////////////////////////////////////////////
  // threshold scaling: 2 g spans half the signed range
  // code to level in mg, the same at every full scale
  function automatic logic [9:0] drop_mg(input logic [2:0] code);
    unique case (code)
      3'h0: drop_mg = `DROP_MG_0;
      3'h1: drop_mg = `DROP_MG_1;
      3'h2: drop_mg = `DROP_MG_2;
      3'h3: drop_mg = `DROP_MG_3;
      3'h4: drop_mg = `DROP_MG_4;
      3'h5: drop_mg = `DROP_MG_5;
      3'h6: drop_mg = `DROP_MG_6;
      3'h7: drop_mg = `DROP_MG_7;
    endcase
  endfunction

  // magnitude of a raw sample; the most negative code stays large
  function automatic logic [W-1:0] abs_raw(input logic [W-1:0] v);
    logic [W-1:0] a;
    a = v[W-1] ? -v : v;
    abs_raw = a;
  endfunction

  always_comb begin
    logic [W+15:0] prod;
    logic [W-1:0] fs_unit;
    prod = '0;
    fs_unit = '0;
    // mg to counts at current full scale, independent of scale in mg
    prod = (W+16)'(drop_mg(drop_threshold_code)) * (W+16)'(1 << (W - 1)); // see (R7)
    drop_lsb = W'((prod / (W+16)'(`FS_BASE_MG)) >> accel_full_scale);
    // full scale maps to half range; step is that over 64
    fs_unit = W'(1 << (W - 1));
    wake_lsb = W'(fs_unit >> `WAKE_STEP_SHIFT) * W'(wake_threshold_field); // see (R11)
  end

  ////////////////////////////////////////////////////////////////
  // per axis comparisons
  // zone test on raw data, wake test on filtered data
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    assign in_zone[i] = abs_raw(raw[i]) <= drop_lsb; // see (R1)
    assign over[i] = mag[i] > wake_lsb; // see (R10)
  end

  assign drop_cond = &in_zone; // see (R1)
  assign wake_cond = |over;

  ////////////////////////////////////////////////////////////////
  // duration counters, stepped once per sample
  always_comb begin
    drop_cnt_d = drop_cnt_q;
    wake_cnt_d = wake_cnt_q;
    drop_live_d = drop_live_q;
    wake_live_d = wake_live_q;
    axis_d = axis_q;
    drop_hit = 1'b0;
    wake_hit = 1'b0;
    if (!events_enable) begin
      drop_cnt_d = '0;
      wake_cnt_d = '0;
      drop_live_d = 1'b0;
      wake_live_d = 1'b0;
      axis_d = '0;
    end else if (sample_stb) begin // see (R22)
      // free fall: every axis inside the zone
      if (drop_cond) begin
        // saturate so a long fall keeps the event
        if (drop_cnt_q != '1) begin
          drop_cnt_d = drop_cnt_q + 1'b1;
        end
        // count excludes this sample; N plus one samples needed
        drop_hit = drop_cnt_q >= drop_duration_count; // see (R2) (R8)
      end else begin
        drop_cnt_d = '0; // see (R22)
      end
      drop_live_d = drop_hit; // see (R4)
      // wake: any axis over the threshold
      if (wake_cond) begin
        // saturating count of consecutive exceeding samples
        if (wake_cnt_q != '1) begin
          wake_cnt_d = wake_cnt_q + 1'b1;
        end
        // zero duration fires on the first exceeding sample
        wake_hit = wake_cnt_q >= {1'b0, wake_duration_field}; // see (R12) (R13)
      end else begin
        wake_cnt_d = '0;
      end
      wake_live_d = wake_hit; // see (R15) (R18)
      axis_d = wake_hit ? over : '0;
    end
  end

  // counter and live flag registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_cnt_q <= '0;
      wake_cnt_q <= '0;
      drop_live_q <= 1'b0;
      wake_live_q <= 1'b0;
      axis_q <= '0;
    end else begin
      drop_cnt_q <= drop_cnt_d;
      wake_cnt_q <= wake_cnt_d;
      drop_live_q <= drop_live_d;
      wake_live_q <= wake_live_d;
      axis_q <= axis_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // latching, source word and pins
  assign drop_routed = pin1_drop_route | pin2_drop_route;
  assign wake_routed = pin1_wake_route | pin2_wake_route;

  always_comb begin
    drop_latch_d = drop_latch_q;
    wake_latch_d = wake_latch_q;
    src_d = src_q;
    // read clears latches; a new event in the same cycle wins
    if (source_read) begin
      drop_latch_d = 1'b0; // see (R5) (R23)
      wake_latch_d = 1'b0; // see (R16) (R23)
    end
    if (!latch_request || !drop_routed || !events_enable) begin
      drop_latch_d = 1'b0; // see (R6)
    end else if (drop_live_q) begin
      drop_latch_d = 1'b1; // see (R5)
    end
    if (!latch_request || !wake_routed || !events_enable) begin
      wake_latch_d = 1'b0; // see (R6)
    end else if (wake_live_q) begin
      wake_latch_d = 1'b1; // see (R16)
    end
    drop_sig = drop_live_q | drop_latch_q;
    wake_sig = wake_live_q | wake_latch_q;
    // source word: drop, wake and axis flags
    src_d = '0;
    src_d[`SRC_DROP_BIT] = drop_sig; // see (R3)
    src_d[`SRC_WAKE_BIT] = wake_sig; // see (R14)
    // axis flags stay with the wake latch until the read
    src_d[`SRC_X_BIT] = axis_q[0] | (wake_latch_q & src_q[`SRC_X_BIT]);
    src_d[`SRC_Y_BIT] = axis_q[1] | (wake_latch_q & src_q[`SRC_Y_BIT]);
    src_d[`SRC_Z_BIT] = axis_q[2] | (wake_latch_q & src_q[`SRC_Z_BIT]);
    // pins: routed events ORed, polarity applied
    pin1_d = (pin1_drop_route & drop_sig) | (pin1_wake_route & wake_sig); // see (R3) (R14) (R20)
    pin2_d = (pin2_drop_route & drop_sig) | (pin2_wake_route & wake_sig); // see (R20)
    pin1_d = pin1_d ^ pin_polarity_select; // see (R21)
    pin2_d = pin2_d ^ pin_polarity_select; // see (R21)
  end

  // latch, source and pin registers; outputs come from flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_latch_q <= 1'b0;
      wake_latch_q <= 1'b0;
      src_q <= '0;
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
    end else begin
      drop_latch_q <= drop_latch_d;
      wake_latch_q <= wake_latch_d;
      src_q <= src_d;
      pin1_q <= pin1_d;
      pin2_q <= pin2_d;
    end
  end

  // read data is the registered current flags
  assign motion_source_reg = src_q; // see (R23)
  assign event_pin_one = pin1_q;
  assign event_pin_two = pin2_q;
endmodule

// file: hdl/motion_cfg.svh
// constants for the drop and motion event detector
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH
`define SAMPLE_W 16
`define FULL_SCALE_W 2
`define DROP_DUR_W 6
`define DROP_THS_W 3
`define WAKE_THS_W 6
`define WAKE_DURATION_FIELD_W 2
// free-fall level table in mg, per threshold code
`define DROP_MG_0 10'd156
`define DROP_MG_1 10'd219
`define DROP_MG_2 10'd250
`define DROP_MG_3 10'd312
`define DROP_MG_4 10'd344
`define DROP_MG_5 10'd406
`define DROP_MG_6 10'd469
`define DROP_MG_7 10'd500
// full scale of 2 g spans 2000 mg over half the signed sample range
`define FS_BASE_MG 16'd2000
// wake threshold step is full scale divided by 64
`define WAKE_STEP_SHIFT 6
// source word bit positions
`define SRC_X_BIT 0
`define SRC_Y_BIT 1
`define SRC_Z_BIT 2
`define SRC_WAKE_BIT 3
`define SRC_DROP_BIT 5
`endif

// file: hdl/motion_pkg.sv
// types shared by the drop and motion event detector
package motion_pkg;
  typedef logic [2:0] axis_bits_t;
  typedef logic [5:0] source_word_t;
endpackage

// file: hdl/axis_if.sv
// per-axis filtered sample carrier between detector and axis filter
`timescale 1ns/1ps
interface axis_if #(parameter int W = 16);
  logic [W-1:0] raw_x;
  logic [W-1:0] raw_y;
  logic [W-1:0] raw_z;
  logic [W-1:0] mag_x;
  logic [W-1:0] mag_y;
  logic [W-1:0] mag_z;
  modport src (output raw_x, output raw_y, output raw_z, input mag_x, input mag_y, input mag_z);
  modport filt (input raw_x, input raw_y, input raw_z, output mag_x, output mag_y, output mag_z);
endinterface

// file: hdl/wake_filter.sv
// slope or high-pass wake filter, absolute value per axis
`timescale 1ns/1ps
`include "motion_cfg.svh"
module wake_filter
  import motion_pkg::*;
#(
  parameter int W = `SAMPLE_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sample_stb,
  input wire logic filter_enable,
  input wire logic wake_filter_select,
  axis_if.filt ax
);
  logic [W-1:0] prev_q [3];
  logic [W-1:0] prev_d [3];
  logic [W-1:0] hp_q [3];
  logic [W-1:0] hp_d [3];
  logic [W-1:0] mag [3];
  logic [W-1:0] raw [3];

  initial begin
    if (W < 4) $error("sample width too small");
  end

  assign raw[0] = ax.raw_x;
  assign raw[1] = ax.raw_y;
  assign raw[2] = ax.raw_z;

  function automatic logic [W-1:0] abs_val(input logic [W:0] v);
    logic [W:0] a;
    a = v[W] ? -v : v;
    abs_val = a[W] ? {W{1'b1}} : a[W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // per axis filter, previous sample zero after disable
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [W:0] slope;
    logic [W:0] hpf;
    always_comb begin
      slope = ($signed({raw[i][W-1], raw[i]}) - $signed({prev_q[i][W-1], prev_q[i]})) >>> 1;
      hpf = $signed({raw[i][W-1], raw[i]}) - $signed({hp_q[i][W-1], hp_q[i]});
      prev_d[i] = prev_q[i];
      hp_d[i] = hp_q[i];
      if (!filter_enable) begin
        prev_d[i] = '0; // see (R17)
        hp_d[i] = '0;
      end else if (sample_stb) begin
        prev_d[i] = raw[i];
        // first-order baseline tracks at 1/16 per sample
        hp_d[i] = W'($signed(hp_q[i]) + ($signed(hpf) >>> 4));
      end
      mag[i] = wake_filter_select ? abs_val(hpf) : abs_val(slope); // see (R9) (R17)
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        prev_q[i] <= '0;
        hp_q[i] <= '0;
      end else begin
        prev_q[i] <= prev_d[i];
        hp_q[i] <= hp_d[i];
      end
    end
  end

  assign ax.mag_x = mag[0];
  assign ax.mag_y = mag[1];
  assign ax.mag_z = mag[2];
endmodule

// file: sim/host_reader.sv
// host side model: turns a read command into a one-cycle source read
`timescale 1ns/1ps
module host_reader (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic read_cmd,
  output logic source_read
);
  logic armed_q;
  // one read strobe per command, like a single register access
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      source_read <= 1'b0;
    end else begin
      armed_q <= read_cmd;
      source_read <= read_cmd && !armed_q;
    end
  end
endmodule

// file: sim/drop_motion_detect_asserts.sv
// port-level checks of the drop and motion event detector
`timescale 1ns/1ps
module drop_motion_detect_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sample_stb,
  input wire logic events_enable,
  input wire logic latch_request,
  input wire logic pin_polarity_select,
  input wire logic pin1_drop_route,
  input wire logic pin2_drop_route,
  input wire logic pin1_wake_route,
  input wire logic pin2_wake_route,
  input wire logic source_read,
  input wire logic [5:0] motion_source_reg,
  input wire logic event_pin_one,
  input wire logic event_pin_two
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // routing, polarity and latch mode held for three edges
  sequence s_cfg_still;
    $stable({pin_polarity_select, pin1_drop_route, pin2_drop_route, pin1_wake_route,
      pin2_wake_route, latch_request})[*3];
  endsequence
  // no read seen in the last three edges
  sequence s_no_read;
    !source_read && !$past(source_read) && !$past(source_read, 2);
  endsequence
  a_pin_one_or: assert property (
    s_cfg_still |-> event_pin_one == (pin_polarity_select ^ ((motion_source_reg[5]
    && pin1_drop_route) || (motion_source_reg[3] && pin1_wake_route))))
    else $error("pin one level wrong");
  a_pin_two_or: assert property (
    s_cfg_still |-> event_pin_two == (pin_polarity_select ^ ((motion_source_reg[5]
    && pin2_drop_route) || (motion_source_reg[3] && pin2_wake_route))))
    else $error("pin two level wrong");
  a_spare_bit_zero: assert property (motion_source_reg[4] == 1'b0)
    else $error("spare source bit set");
  a_wake_axis_tie: assert property (
    motion_source_reg[3] == (|motion_source_reg[2:0]))
    else $error("wake flag and axis flags disagree");
  a_off_clears: assert property (!events_enable [*3] |-> motion_source_reg == 6'h00)
    else $error("flags shown while disabled");
  a_src_has_cause: assert property (
    $changed(motion_source_reg) |-> $past(sample_stb, 2) || $past(source_read, 2)
    || !$past(events_enable, 2) || !$past(events_enable, 3))
    else $error("source word changed without cause");
  a_drop_latch_hold: assert property (
    latch_request && pin1_drop_route && events_enable && motion_source_reg[5] ##0 s_no_read
    |=> motion_source_reg[5])
    else $error("latched drop lost before read");
  a_wake_latch_hold: assert property (
    latch_request && pin2_wake_route && events_enable && motion_source_reg[3] ##0 s_no_read
    |=> motion_source_reg[3])
    else $error("latched wake lost before read");
endmodule
bind drop_motion_detect drop_motion_detect_asserts i_chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .sample_stb(sample_stb),
  .events_enable(events_enable),
  .latch_request(latch_request),
  .pin_polarity_select(pin_polarity_select),
  .pin1_drop_route(pin1_drop_route),
  .pin2_drop_route(pin2_drop_route),
  .pin1_wake_route(pin1_wake_route),
  .pin2_wake_route(pin2_wake_route),
  .source_read(source_read),
  .motion_source_reg(motion_source_reg),
  .event_pin_one(event_pin_one),
  .event_pin_two(event_pin_two)
);

// file: sim/drop_motion_detect_tb.sv
// self-checking bench for the drop and motion event detector
`timescale 1ns/1ps
module drop_motion_detect_tb;
  import motion_pkg::*;
  logic core_clk, rst_b, sample_stb, en, lat, sel, pol, r1d, r2d, r1w, r2w, rdc, srd, p1, p2;
  logic [15:0] ax, ay, az;
  logic [1:0] fs, wkd;
  logic [2:0] ffc, dly;
  logic [5:0] ffn, wkt;
  source_word_t src;
  logic [7:0] exp_q[$];
  logic [31:0] seed;
  int err_count, tests_run, cyc, thr;
  int mg[8] = '{156, 219, 250, 312, 344, 406, 469, 500};
  drop_motion_detect i_dut (.core_clk(core_clk), .rst_b(rst_b), .sample_stb(sample_stb),
    .accel_x(ax), .accel_y(ay), .accel_z(az), .accel_full_scale(fs), .events_enable(en),
    .latch_request(lat), .wake_filter_select(sel), .pin_polarity_select(pol),
    .pin1_drop_route(r1d), .pin2_drop_route(r2d), .pin1_wake_route(r1w),
    .pin2_wake_route(r2w), .drop_threshold_code(ffc), .drop_duration_count(ffn),
    .wake_threshold_field(wkt), .wake_duration_field(wkd), .source_read(srd),
    .motion_source_reg(src), .event_pin_one(p1), .event_pin_two(p2));
  host_reader i_host (.core_clk(core_clk), .rst_b(rst_b), .read_cmd(rdc), .source_read(srd));
  ////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one sample strobe; expected source word and pin levels join the queue
  task automatic smp(input logic [15:0] x, y, z, input logic [5:0] s, input logic l1, l2);
    @(posedge core_clk);
    sample_stb <= 1'b1;
    ax <= x;
    ay <= y;
    az <= z;
    exp_q.push_back({s, pol ^ l1, pol ^ l2});
    @(posedge core_clk);
    sample_stb <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rd();
    @(posedge core_clk);
    rdc <= 1'b1;
    @(posedge core_clk);
    rdc <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // results settle two edges after the strobe is taken
  always @(posedge core_clk) dly <= {dly[1:0], sample_stb};
  always @(negedge core_clk) begin
    if (dly[2] === 1'b1) begin
      if (exp_q.size() == 0)
        chk(8'hff, 8'h00);
      else
        chk({src, p1, p2}, exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 4000) begin
      err_count++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    {rst_b, sample_stb, en, lat, sel, pol, r2d, r1w, r2w, rdc} = 10'h0;
    r1d = 1'b1;
    {ax, ay, az, fs, wkd, ffc, wkt} = 61'h0;
    ffn = 6'd2;
    wkt = 6'd1;
    seed = 32'h12ef;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    smp(16'h0, 16'h0, 16'h0, 6'h00, 0, 0);
    en <= 1'b1;
    smp(16'h0, 16'h0, 16'h0, 6'h00, 0, 0);
    smp(16'h0, 16'h0, 16'h0, 6'h00, 0, 0);
    smp(16'h0, 16'h0, 16'h0, 6'h20, 1, 0);
    r1w <= 1'b1;
    r2w <= 1'b1;
    smp(16'h4000, 16'h0, 16'h0, 6'h09, 1, 1);
    smp(16'h4000, 16'h0, 16'h0, 6'h00, 0, 0);
    smp(16'h4000, 16'hf000, 16'h0, 6'h0a, 1, 1);
    smp(16'h4000, 16'hf000, 16'h0, 6'h00, 0, 0);
    wkd <= 2'd1;
    pol <= 1'b1;
    smp(16'h4000, 16'hf000, 16'h1000, 6'h00, 0, 0);
    smp(16'h4000, 16'hf000, 16'h2000, 6'h0c, 1, 1);
    smp(16'h4000, 16'hf000, 16'h2000, 6'h00, 0, 0);
    {pol, wkd, lat} <= 4'h1;
    smp(16'h4000, 16'hf000, 16'h3000, 6'h0c, 1, 1);
    smp(16'h4000, 16'hf000, 16'h3000, 6'h0c, 1, 1);
    rd();
    smp(16'h4000, 16'hf000, 16'h3000, 6'h00, 0, 0);
    wkt <= 6'h3f;
    ffn <= 6'd0;
    smp(16'h0, 16'h0, 16'h0, 6'h20, 1, 0);
    smp(16'h4000, 16'h0, 16'h0, 6'h20, 1, 0);
    rd();
    smp(16'h4000, 16'h0, 16'h0, 6'h00, 0, 0);
    r1d <= 1'b0;
    smp(16'h0, 16'h0, 16'h0, 6'h20, 0, 0);
    smp(16'h4000, 16'h0, 16'h0, 6'h00, 0, 0);
    r1d <= 1'b1;
    lat <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      ffc <= (i > 7) ? 3'd7 : 3'(i);
      fs <= (i > 7) ? 2'd3 : 2'd0;
      thr = (mg[(i > 7) ? 7 : i] * 32768 / 2000) >> ((i > 7) ? 3 : 0);
      seed = xs(seed);
      smp(16'(-thr), {6'h0, seed[9:0]}, {6'h0, seed[19:10]}, 6'h20, 1, 0);
      smp(16'(thr + 1), {6'h0, seed[9:0]}, 16'h0, 6'h00, 0, 0);
    end
    {wkt, ffn, en} <= 13'h0fe;
    repeat (2) @(posedge core_clk);
    en <= 1'b1;
    smp(16'h0400, 16'h0, 16'h0, 6'h00, 0, 0);
    smp(16'h0802, 16'h0, 16'h0, 6'h09, 1, 1);
    en <= 1'b0;
    sel <= 1'b1;
    repeat (2) @(posedge core_clk);
    en <= 1'b1;
    smp(16'h0300, 16'h0, 16'h0, 6'h09, 1, 1);
    repeat (5) @(posedge core_clk);
    complete_run();
  end
endmodule
